// *** hdl/iobb_bridge.sv ***
/*
 * Data gating and skip counting part of a bridge between a processor bus
 * and a positive-logic peripheral bus, with an APB register slave.
 * Assumes the I/O pulse sequencer sits on pclk and delivers one-cycle
 * fire pulses for the strobe, gap and final-delay one-shots and for the
 * end of each I/O instruction. Peripheral pins are asynchronous.
 */
// Functional notes
// [RQ1] Processor data inverted onto external output lines
// [RQ2] Clear request during pulse asserts control zero
// [RQ3] No clear request: control lines stay negated
// [RQ4] Any input one raises data present
// [RQ5] Peripheral drives input word during I/O pulse
// [RQ6] Data present: control one, word onto bus
// [RQ7] Overwrite input adds control zero too
// [RQ8] Zero word needs clear request from peripheral
// [RQ9] Every input transfer asserts a control line
// [RQ10] Peripheral grounds skip, leaves input lines idle
// [RQ11] Skip count on data lines ten, eleven
// [RQ12] Skip sample takes skip level at strobe
// [RQ13] Gap one-shot sets skip sample, priority
// [RQ14] Each sample clear clocks two-stage counter
// [RQ15] Final delay sets enable over strobe
// [RQ16] Enable drives control two only
// [RQ17] Control two plus final strobe loads counter
// [RQ18] Peripheral releases skip before final strobe
// [RQ19] Strobe issued at end of each pulse
// [RQ20] Final delay then one more strobe
// [RQ21] Counter and enable cleared per instruction
`timescale 1ns/100ps
`include "iobb_cfg.svh"

module iobb_bridge (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer events, all on pclk
    input wire logic io_pulse,
    input wire logic strobe_oneshot_fire,
    input wire logic gap_oneshot_fire,
    input wire logic final_delay_oneshot_fire,
    input wire logic io_instruction_done,
    // Processor bus
    input wire logic [11:0] proc_data_in,
    output logic [11:0] proc_data_out,
    // Low while the bridge drives the processor data lines
    output logic proc_data_oe_n,
    output logic ctrl_line_zero_n,
    output logic ctrl_line_one_n,
    output logic ctrl_line_two_n,
    output logic prog_counter_load_n,
    output logic bus_strobe_n,
    // Peripheral bus
    output logic [11:0] ext_out_data,
    input wire logic [11:0] ext_in_data,
    input wire logic acc_clear_request_n,
    input wire logic skip_request_n
);

    iobb_pkg::iobb_state_t s_r;   // Registered state
    iobb_pkg::iobb_state_t s_nxt; // Next state

    logic [13:0] pins_s;          // Synchronised peripheral pins
    logic [11:0] in_s;            // Input word after synchronising
    logic clear_req;              // Accumulator clear requested
    logic skip_req;               // Skip requested
    logic data_present;           // Some input line carries a one
    logic [1:0] count_nxt;        // Next value of the skip counter
    logic [1:0] count_r;          // Current value of the skip counter
    logic sample_falls;           // Skip sample goes from set to clear
    logic setup_phase;            // APB setup cycle
    logic wr_access;              // APB write access cycle
    iobb_pkg::iobb_reg_t rd_sel;  // Register picked by the read
    iobb_pkg::iobb_reg_t wr_sel;  // Register picked by the write

    // Address decode shared by the read and write paths
    function automatic iobb_pkg::iobb_reg_t reg_decode(input logic [11:0] a);
        iobb_pkg::iobb_reg_t r;
        case (a)
            `IOBB_OFS_CTRL: r = iobb_pkg::IOBB_REG_CTRL;
            `IOBB_OFS_STATUS: r = iobb_pkg::IOBB_REG_STATUS;
            `IOBB_OFS_LAST_IN: r = iobb_pkg::IOBB_REG_LAST_IN;
            default: r = iobb_pkg::IOBB_REG_NONE;
        endcase
        return r;
    endfunction

    // Peripheral pins are asynchronous, so they pass two flops first
    // The reset value is the released level, so no false request follows reset
    iobb_sync #(
        .W(14),
        .RST(`IOBB_PIN_IDLE)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({skip_request_n, acc_clear_request_n, ext_in_data}),
        .q(pins_s)
    );

    assign in_s = pins_s[11:0];
    assign clear_req = !pins_s[12];
    assign skip_req = !pins_s[13];
    assign data_present = |in_s; // RQ4
    assign count_r = {s_r.count_high_stage, s_r.count_low_stage};

    // Zero wait states: every access completes in its first access cycle
    // Read data is registered at the setup edge, which is what makes that possible
    assign pready = 1'b1;
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign rd_sel = reg_decode(paddr);
    assign wr_sel = reg_decode(paddr);

    // Next-state logic for the whole bridge
    always_comb begin
        s_nxt = s_r;
        sample_falls = 1'b0;
        count_nxt = count_r;

        // Output path is a plain buffer-inverter, registered for clean edges
        s_nxt.ext_out = ~proc_data_in; // RQ1

        // Skip sample: the gap one-shot set wins over the strobe clock
        if (gap_oneshot_fire) begin
            s_nxt.skip_sample_ff = 1'b1; // RQ13
        end else if (strobe_oneshot_fire) begin
            // D input is the raw line level: an asserted (low) skip clears the
            // sample, and each such clear is one counted skip
            s_nxt.skip_sample_ff = !skip_req; // RQ12
        end

        // A set-to-clear move of the sample clocks the counter
        // The counter wraps after three; the peripheral must not skip further
        sample_falls = s_r.skip_sample_ff && !s_nxt.skip_sample_ff;
        if (sample_falls) begin
            count_nxt = count_r + 2'd1; // RQ14
        end

        // Final delay sets the enable even when the strobe fires with it
        if (final_delay_oneshot_fire) begin
            s_nxt.ctrl_line_enable_ff = 1'b1; // RQ15
        end

        // End of the instruction wipes count and enable, it has the last word
        if (io_instruction_done) begin
            count_nxt = 2'd0; // RQ21
            s_nxt.ctrl_line_enable_ff = 1'b0; // RQ21
        end
        s_nxt.count_low_stage = count_nxt[0];
        s_nxt.count_high_stage = count_nxt[1];

        // Control lines and processor data default to released
        s_nxt.ctrl0 = 1'b0; // RQ3
        s_nxt.ctrl1 = 1'b0; // RQ3
        s_nxt.ctrl2 = 1'b0;
        s_nxt.data_oe = 1'b0;
        s_nxt.data_out = '0;

        if (!s_r.enable) begin
            // Disabled: the bridge keeps every processor line negated
            s_nxt.ctrl0 = 1'b0;
        end else if (s_nxt.ctrl_line_enable_ff && count_nxt != 2'd0) begin
            // Skip: only control two, count on lines ten and eleven
            // Skip routing wins over a pulse, as control enable holds to the end
            s_nxt.ctrl2 = 1'b1; // RQ16
            s_nxt.data_out = {10'h000, count_nxt}; // RQ11
            s_nxt.data_oe = 1'b1;
        end else if (io_pulse) begin
            // Clear request asserts control zero, on output or overwrite input
            s_nxt.ctrl0 = clear_req; // RQ2 RQ7
            // Present data asserts control one and is ORed into the AC
            if (data_present) begin
                s_nxt.ctrl1 = 1'b1; // RQ6 RQ9
                s_nxt.data_out = in_s; // RQ6
                s_nxt.data_oe = 1'b1;
                s_nxt.last_in = in_s;
            end else if (clear_req) begin
                // Overwrite input of zeros is logged as a zero word
                s_nxt.last_in = '0;
            end
            // Without clear or data nothing is asserted at all
        end

        // Strobe at each pulse end and after the final delay
        // A disabled bridge must not strobe, or the processor would load garbage
        s_nxt.bus_strobe = s_r.enable && strobe_oneshot_fire; // RQ19 RQ20
        // Control two with the final strobe loads the program counter
        // Both terms come from s_nxt so the load lines up with the strobe cycle
        s_nxt.pc_load = s_nxt.bus_strobe && s_nxt.ctrl2; // RQ17

        // APB write, taken in the access cycle only
        if (wr_access && wr_sel == iobb_pkg::IOBB_REG_CTRL) begin
            s_nxt.enable = pwdata[`IOBB_CTRL_ENABLE_BIT];
        end

        // APB read data and error, prepared during the setup cycle
        if (setup_phase) begin
            s_nxt.prdata = 32'h0000_0000;
            s_nxt.pslverr = 1'b0;
            case (rd_sel)
                iobb_pkg::IOBB_REG_CTRL: begin
                    s_nxt.prdata[`IOBB_CTRL_ENABLE_BIT] = s_r.enable;
                end
                iobb_pkg::IOBB_REG_STATUS: begin
                    s_nxt.prdata[`IOBB_ST_COUNT_LO] = s_r.count_low_stage;
                    s_nxt.prdata[`IOBB_ST_COUNT_HI] = s_r.count_high_stage;
                    s_nxt.prdata[`IOBB_ST_ENABLE_FF_BIT] = s_r.ctrl_line_enable_ff;
                    s_nxt.prdata[`IOBB_ST_SAMPLE_BIT] = s_r.skip_sample_ff;
                    s_nxt.prdata[`IOBB_ST_PRESENT_BIT] = data_present;
                    s_nxt.prdata[`IOBB_ST_CLEAR_BIT] = clear_req;
                end
                iobb_pkg::IOBB_REG_LAST_IN: begin
                    s_nxt.prdata[11:0] = s_r.last_in;
                end
                default: begin
                    // Unmapped address answers with an error
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register; the reset value of every field is a constant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            // Only the enable bit of the control reset word is held in a flop
            s_r.enable <= 1'(`IOBB_CTRL_RESET);
            s_r.ext_out <= 12'hFFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // All data and control outputs except the tied-high pready come straight from flip-flops
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr;
    assign ext_out_data = s_r.ext_out;
    assign proc_data_out = s_r.data_out;
    assign proc_data_oe_n = !s_r.data_oe;
    assign ctrl_line_zero_n = !s_r.ctrl0;
    assign ctrl_line_one_n = !s_r.ctrl1;
    assign ctrl_line_two_n = !s_r.ctrl2;
    assign prog_counter_load_n = !s_r.pc_load;
    assign bus_strobe_n = !s_r.bus_strobe;

    // Checks on the bridge's own outputs and internal skip state
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Checks read s_nxt where the decision rests on this cycle's inputs

    chk_out_invert: assert property ( // RQ1
        ##1 ext_out_data == ~$past(proc_data_in)
    ) else $error("output data not inverted copy of processor data");

    chk_clear_zero: assert property ( // RQ2
        io_pulse && s_r.enable && clear_req && !s_nxt.ctrl2 |=> !ctrl_line_zero_n
    ) else $error("clear request did not assert control zero");

    chk_quiet_ctrl: assert property ( // RQ3
        io_pulse && !clear_req && !data_present && !s_nxt.ctrl2
        |=> ctrl_line_zero_n && ctrl_line_one_n && ctrl_line_two_n && proc_data_oe_n
    ) else $error("control line asserted on plain output transfer");

    chk_or_input: assert property ( // RQ6
        io_pulse && s_r.enable && data_present && !s_nxt.ctrl2
        |=> !ctrl_line_one_n && !proc_data_oe_n && proc_data_out == $past(in_s)
    ) else $error("input word not gated with control one");

    chk_overwrite_in: assert property ( // RQ7
        io_pulse && s_r.enable && data_present && clear_req && !s_nxt.ctrl2
        |=> !ctrl_line_zero_n && !ctrl_line_one_n
    ) else $error("overwrite input lacks control zero or one");

    chk_input_ctrl: assert property ( // RQ9
        !proc_data_oe_n && ctrl_line_two_n |-> !ctrl_line_zero_n || !ctrl_line_one_n
    ) else $error("input transfer without a control line");

    chk_sample_take: assert property ( // RQ12
        strobe_oneshot_fire && !gap_oneshot_fire |=> s_r.skip_sample_ff == !$past(skip_req)
    ) else $error("skip sample did not take the skip level");

    chk_sample_set: assert property ( // RQ13
        gap_oneshot_fire |=> s_r.skip_sample_ff
    ) else $error("gap one-shot did not set skip sample");

    chk_count_step: assert property ( // RQ14
        s_r.skip_sample_ff && strobe_oneshot_fire && !gap_oneshot_fire && skip_req
        && !io_instruction_done |=> count_r == $past(count_r) + 2'd1
    ) else $error("skip counter missed a count");

    chk_enable_prio: assert property ( // RQ15
        final_delay_oneshot_fire && !io_instruction_done |=> s_r.ctrl_line_enable_ff
    ) else $error("final delay did not set control enable");

    chk_skip_route: assert property ( // RQ16 RQ11
        s_r.enable && s_r.ctrl_line_enable_ff && count_r != 2'd0
        |-> !ctrl_line_two_n && ctrl_line_zero_n && ctrl_line_one_n
        && proc_data_out == {10'h000, count_r}
    ) else $error("skip count not routed with control two only");

    chk_pc_load: assert property ( // RQ17
        !prog_counter_load_n |-> !ctrl_line_two_n && !bus_strobe_n && $past(strobe_oneshot_fire)
    ) else $error("program counter load without strobe and control two");

    chk_strobe_out: assert property ( // RQ19 RQ20
        strobe_oneshot_fire && s_r.enable |=> !bus_strobe_n
    ) else $error("bus strobe missing after strobe one-shot");

    chk_done_clear: assert property ( // RQ21
        io_instruction_done |=> count_r == 2'd0 && !s_r.ctrl_line_enable_ff
    ) else $error("instruction end did not clear skip state");

    cov_or_input: cover property (
        io_pulse && data_present && !clear_req ##1 !ctrl_line_one_n
    );

    cov_zero_overwrite: cover property (
        io_pulse && !data_present && clear_req ##1 !ctrl_line_zero_n
    );

    cov_skip_two: cover property (
        count_r == 2'd2 && !prog_counter_load_n
    );

    cov_overwrite_word: cover property (
        io_pulse && data_present && clear_req ##1 !ctrl_line_zero_n && !ctrl_line_one_n
    );

    cov_apb_error: cover property (
        psel && penable && pslverr
    );

endmodule

// *** hdl/iobb_cfg.svh ***
/*
 * Constants of the I/O bus data and skip bridge: register offsets,
 * field positions and reset values.
 * Assumes it is included by bare name, before the package and the modules.
 */
`ifndef IOBB_CFG_SVH
`define IOBB_CFG_SVH

// Register byte offsets on the APB slave
`define IOBB_OFS_CTRL 12'h000
`define IOBB_OFS_STATUS 12'h004
`define IOBB_OFS_LAST_IN 12'h008

// Control register fields
`define IOBB_CTRL_ENABLE_BIT 0
`define IOBB_CTRL_RESET 32'h0000_0001

// Status register fields
`define IOBB_ST_COUNT_LO 0
`define IOBB_ST_COUNT_HI 1
`define IOBB_ST_ENABLE_FF_BIT 2
`define IOBB_ST_SAMPLE_BIT 3
`define IOBB_ST_PRESENT_BIT 4
`define IOBB_ST_CLEAR_BIT 5

// Width of the data paths on both buses
`define IOBB_DW 12

// Idle value of the peripheral pins after reset: skip and clear released
`define IOBB_PIN_IDLE 14'h3000

`endif

// *** hdl/iobb_pkg.sv ***
/*
 * Types of the I/O bus data and skip bridge.
 * Assumes iobb_cfg.svh is compiled alongside; nothing is imported anywhere.
 */
`include "iobb_cfg.svh"

package iobb_pkg;

    // Register selected by an APB address
    typedef enum logic [1:0] {
        IOBB_REG_CTRL = 2'h0,
        IOBB_REG_STATUS = 2'h1,
        IOBB_REG_LAST_IN = 2'h3,
        IOBB_REG_NONE = 2'h2
    } iobb_reg_t;

    // Whole state of the bridge top level
    typedef struct packed {
        logic skip_sample_ff;                // Skip level caught at each strobe
        logic count_low_stage;               // Skip counter, weight one
        logic count_high_stage;              // Skip counter, weight two
        logic ctrl_line_enable_ff;           // Routes skip bits to the program counter
        logic ctrl0;                         // Control line zero, active high inside
        logic ctrl1;                         // Control line one, active high inside
        logic ctrl2;                         // Control line two, active high inside
        logic pc_load;                       // Program counter load pulse
        logic bus_strobe;                    // Bus strobe pulse
        logic [`IOBB_DW-1:0] data_out;       // Word driven onto processor data lines
        logic data_oe;                       // Processor data lines driven
        logic [`IOBB_DW-1:0] ext_out;        // Inverted copy of processor data
        logic enable;                        // Software enable of the bridge
        logic [`IOBB_DW-1:0] last_in;        // Last input word gated to the processor
        logic [31:0] prdata;                 // APB read data
        logic pslverr;                       // APB error answer
    } iobb_state_t;

endpackage

// *** hdl/iobb_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit is an independent level; no bus coherence is promised.
 */
`timescale 1ns/100ps

module iobb_sync #(
    parameter int W = 14,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r; // First stage, read only by the second

    // Both stages reset to the idle value of the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RST;
            q <= RST;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// *** dv/iobb_periph.sv ***
/*
 * Behavioural peripheral on the positive-logic I/O bus.
 * Assumes the bench commands it on pclk; released lines settle at the
 * receiver's pull levels: data low, clear and skip high.
 */
`timescale 1ns/100ps

module iobb_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] op,
    input wire logic [11:0] word,
    input wire logic clr,
    output logic [11:0] ext_in_data,
    output logic acc_clear_request_n,
    output logic skip_request_n
);
    // Op codes: 0 idle, 1 or-input, 2 overwrite input, 3 skip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_in_data <= 12'h000;
            acc_clear_request_n <= 1'b1;
            skip_request_n <= 1'b1;
        end else begin
            // Word only for an input; during a skip the lines stay released
            ext_in_data <= (op == 2'h1 || op == 2'h2) ? word : 12'h000;
            // Clear grounded for an overwrite, a zero load or an output clear
            acc_clear_request_n <= !(clr || op == 2'h2);
            // Skip held only while commanded, so the bench decides the release
            skip_request_n <= (op != 2'h3);
        end
    end
endmodule

// *** dv/iobb_bridge_tb.sv ***
/*
 * Self-checking bench of the I/O bus data and skip bridge.
 * Assumes the sequencer events are single-cycle pulses on pclk.
 */
`timescale 1ns/100ps
`include "iobb_cfg.svh"

module iobb_bridge_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, io_pulse, oe_n, clr, peek;
    logic c0_n, c1_n, c2_n, pcl_n, bs_n, clr_n, skip_n;
    logic [11:0] paddr, pdin, pdout, ext_out, ext_in, word, w;
    logic [31:0] pwdata, prdata, seed;
    logic [3:0] ev; // Strobe, gap, final delay, instruction end
    logic [1:0] op;
    logic [2:0] prev_c;
    logic [39:0] got;
    logic [79:0] nt;
    logic got_v;
    logic [79:0] notes[$]; // Expected value and mask, oldest first
    int err_count, cmp_count;

    iobb_bridge i_iobb_bridge (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .io_pulse(io_pulse), .strobe_oneshot_fire(ev[0]),
        .gap_oneshot_fire(ev[1]), .final_delay_oneshot_fire(ev[2]),
        .io_instruction_done(ev[3]), .proc_data_in(pdin), .proc_data_out(pdout),
        .proc_data_oe_n(oe_n), .ctrl_line_zero_n(c0_n), .ctrl_line_one_n(c1_n),
        .ctrl_line_two_n(c2_n), .prog_counter_load_n(pcl_n), .bus_strobe_n(bs_n),
        .ext_out_data(ext_out), .ext_in_data(ext_in), .acc_clear_request_n(clr_n),
        .skip_request_n(skip_n));

    iobb_periph i_iobb_periph (.pclk(pclk), .presetn(presetn), .op(op), .word(word),
        .clr(clr), .ext_in_data(ext_in), .acc_clear_request_n(clr_n), .skip_request_n(skip_n));

    // Free-running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Fixed-seed xorshift so every run repeats
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Control-line event: {pc load, strobe, c0, c1, c2} then the data word;
    // a seen event carries the undriven flag of the data lines in bit 17
    function automatic logic [39:0] cev(input logic [4:0] f, input logic [11:0] d);
        return {8'h01, 15'h0000, f, d};
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input logic [39:0] e, input logic [39:0] m);
        notes.push_back({e, m});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic e, input logic [31:0] v, input logic [31:0] m);
        note({7'h00, e, v}, {8'hff, m});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Single-cycle sequencer pulses
    task automatic fire(input logic [3:0] v);
        @(posedge pclk) ev <= v;
        @(posedge pclk) ev <= 4'h0;
    endtask

    // Lines settle past the synchroniser before the pulse; strobe follows it
    task automatic xfer(input logic [1:0] o, input logic [11:0] d, input logic c);
        @(posedge pclk);
        op <= o;
        word <= d;
        clr <= c;
        tick(4);
        @(posedge pclk) io_pulse <= 1'b1;
        tick(3);
        @(posedge pclk) io_pulse <= 1'b0;
        fire(4'h1);
        @(posedge pclk);
        op <= 2'h0;
        clr <= 1'b0;
        tick(4);
    endtask

    // n counted skips, then the final strobe with skip released or held
    task automatic skip(input logic [1:0] n, input logic hold);
        @(posedge pclk) op <= 2'h3;
        tick(4);
        repeat (n) begin
            fire(4'h2);
            note(40'h02_0000_0000, 40'hff_ffff_ffff);
            fire(4'h1);
        end
        @(posedge pclk) op <= hold ? 2'h3 : 2'h0;
        tick(4);
        fire(4'h2);
        note(cev(5'h06, {10'h000, n}), hold ? 40'hff_0001_f000 : 40'hff_0001_f003);
        fire(4'h5);
        tick(3);
        rd(`IOBB_OFS_STATUS, 1'b0, {29'h0, 1'b1, n + {1'b0, hold}}, 32'h0000_0007);
        fire(4'h8);
        tick(2);
        rd(`IOBB_OFS_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0007);
        @(posedge pclk) op <= 2'h0;
        tick(4);
    endtask

    // Monitor: each result seen takes the oldest note off the queue
    always @(posedge pclk) begin
        got_v = 1'b0;
        if (presetn && psel && penable && pready && !pwrite) begin
            got = {7'h00, pslverr, prdata};
            got_v = 1'b1;
        end else if ({c0_n, c1_n, c2_n} != 3'b111 && prev_c == 3'b111) begin
            got = cev({pcl_n, bs_n, c0_n, c1_n, c2_n}, pdout) | {22'h00_0000, oe_n, 17'h0_0000};
            got_v = 1'b1;
        end else if (bs_n === 1'b0 && {c0_n, c1_n, c2_n} === 3'b111) begin
            got = 40'h02_0000_0000;
            got_v = 1'b1;
        end else if (peek) begin
            got = {8'h03, 20'h0_0000, ext_out};
            got_v = 1'b1;
        end
        prev_c = {c0_n, c1_n, c2_n};
        if (got_v && notes.size() == 0) begin
            check(got, 40'h00_0000_0000);
        end else if (got_v) begin
            nt = notes.pop_front();
            check(got & nt[39:0], nt[79:40] & nt[39:0]);
        end
    end

    // Hang guard
    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, io_pulse, clr, peek} = 6'h00;
        {paddr, pwdata, pdin, word, op, ev} = '0;
        prev_c = 3'b111;
        seed = 32'h7168;
        presetn = 1'b0;
        tick(5);
        presetn <= 1'b1;
        // Register map, unmapped and read-only places
        rd(`IOBB_OFS_CTRL, 1'b0, `IOBB_CTRL_RESET, 32'hffff_ffff);
        rd(`IOBB_OFS_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0007);
        rd(`IOBB_OFS_LAST_IN, 1'b0, 32'h0000_0000, 32'hffff_ffff);
        rd(12'h00c, 1'b1, 32'h0000_0000, 32'hffff_ffff);
        apb(1'b1, `IOBB_OFS_CTRL, 32'hffff_ffff);
        apb(1'b1, `IOBB_OFS_STATUS, 32'hffff_ffff);
        rd(`IOBB_OFS_CTRL, 1'b0, 32'h0000_0001, 32'hffff_ffff);
        $display("test registers done");
        // Output words reach the peripheral inverted
        repeat (4) begin
            seed = xs(seed);
            @(posedge pclk) pdin <= seed[11:0];
            tick(2);
            @(posedge pclk) peek <= 1'b1;
            note({8'h03, 20'h0_0000, ~seed[11:0]}, 40'hff_ffff_ffff);
            @(posedge pclk) peek <= 1'b0;
        end
        $display("test output data done");
        // Or-input and overwrite input of nonzero words
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            w = seed[11:0] | 12'h800;
            note(cev(k[0] ? 5'h19 : 5'h1d, w), 40'hff_ffff_ffff);
            note(40'h02_0000_0000, 40'hff_ffff_ffff);
            xfer(k[0] ? 2'h2 : 2'h1, w, 1'b0);
            rd(`IOBB_OFS_LAST_IN, 1'b0, {20'h0_0000, w}, 32'hffff_ffff);
        end
        // Overwrite of zeros needs the clear line alone
        note(cev(5'h1b, 12'h000), 40'hff_0001_f000);
        note(40'h02_0000_0000, 40'hff_ffff_ffff);
        xfer(2'h2, 12'h000, 1'b0);
        rd(`IOBB_OFS_LAST_IN, 1'b0, 32'h0000_0000, 32'hffff_ffff);
        $display("test input done");
        // Output with and without accumulator clear
        note(cev(5'h1b, 12'h000), 40'hff_0001_f000);
        note(40'h02_0000_0000, 40'hff_ffff_ffff);
        xfer(2'h0, 12'h000, 1'b1);
        note(40'h02_0000_0000, 40'hff_ffff_ffff);
        xfer(2'h0, 12'h000, 1'b0);
        $display("test output clear done");
        // Skip counts one to three, then skip held over the final strobe
        for (int k = 1; k < 4; k++) begin
            skip(k[1:0], 1'b0);
        end
        skip(2'h2, 1'b1);
        $display("test skip done");
        // Disabled bridge leaves every processor line quiet
        apb(1'b1, `IOBB_OFS_CTRL, 32'h0000_0000);
        xfer(2'h1, 12'h5a5, 1'b0);
        apb(1'b1, `IOBB_OFS_CTRL, 32'h0000_0001);
        tick(3);
        $display("test disable done");
        if (notes.size() != 0) begin
            err_count++;
        end
        complete_run();
    end
endmodule
